// [sim/sbsc_bus_master.sv]
`timescale 1ns/1ps
module sbsc_bus_master
    import sbsc_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              driveEn,
    input  wire logic              oeReqN,
    input  wire logic [DATA_W-1:0] wrData,
    output logic      [DATA_W-1:0] dataIn,
    output logic                   outputEnableN
);
    // ----
    // Bus side
    // ----
    logic [DATA_W-1:0] junk = 18'h2AAAA;
    // Released bus toggles, so a stale word never looks valid
    always @(posedge ref_clk) junk <= ~junk;
    assign dataIn = driveEn ? wrData : junk;
    // Output enable kept off while write data is on the bus
    assign outputEnableN = oeReqN | driveEn;
endmodule

// [sim/sbsc_sram_control_chk.sv]
`timescale 1ns/1ps
module sbsc_sram_control_chk (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic chipSelectPrimaryN,
    input wire logic chipSelectHigh,
    input wire logic chipSelectExtraN,
    input wire logic procAddrStrobeN,
    input wire logic ctrlAddrStrobeN,
    input wire logic allLanesWriteN,
    input wire logic laneWriteEnableN,
    input wire logic laneAWriteN,
    input wire logic laneBWriteN,
    input wire logic outputEnableN,
    input wire logic dataOe,
    input wire logic writeCycle
);
    // ----
    // Decode
    // ----
    logic sel, pStart, cStart, wrReq;
    assign sel = !chipSelectPrimaryN && chipSelectHigh && !chipSelectExtraN;
    assign pStart = !procAddrStrobeN && !chipSelectPrimaryN;
    assign cStart = !ctrlAddrStrobeN && !pStart;
    assign wrReq = !allLanesWriteN || (!laneWriteEnableN && !(laneAWriteN && laneBWriteN));
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Pin drive and write behaviour
    a_drive_needs_oe: assert property (dataOe |-> !outputEnableN)
        else $error("drive without enable");
    a_write_floats: assert property (writeCycle |-> !dataOe)
        else $error("drive during write");
    a_deselect_float: assert property (cStart && !sel |=> !dataOe && !writeCycle)
        else $error("deselect not idle");
    a_extra_select: assert property (cStart && chipSelectExtraN |=> !writeCycle)
        else $error("write with extra select off");
    a_proc_reads: assert property (pStart && sel |=> !writeCycle)
        else $error("proc start wrote");
    a_ctrl_write: assert property (cStart && sel && wrReq |=> writeCycle)
        else $error("ctrl write missed");
    a_global_write: assert property (!allLanesWriteN && laneWriteEnableN && cStart && sel
        |=> writeCycle) else $error("global write missed");
    a_no_write_req: assert property (!wrReq |=> !writeCycle)
        else $error("write without request");
    a_read_drives: assert property ((pStart || cStart && !wrReq) && sel ##1 !outputEnableN
        |-> dataOe) else $error("read not driven");
    c_write: cover property (cStart && sel && wrReq);
    c_proc: cover property (pStart && sel);
    c_desel: cover property (cStart && !sel);
endmodule

bind sbsc_sram_control sbsc_sram_control_chk u_chk (.ref_clk, .sys_rst, .chipSelectPrimaryN,
    .chipSelectHigh, .chipSelectExtraN, .procAddrStrobeN, .ctrlAddrStrobeN, .allLanesWriteN,
    .laneWriteEnableN, .laneAWriteN, .laneBWriteN, .outputEnableN, .dataOe, .writeCycle);

// [sim/sbsc_sram_control_tb.sv]
`timescale 1ns/1ps
module sbsc_sram_control_tb;
    import sbsc_pkg::*;
    logic ref_clk = 0, sys_rst = 1, cs1N = 0, cs2 = 1, cs3N = 0, procN = 1, ctrlN = 1;
    logic stepN = 1, order = 0, gwN = 1, weN = 1, laN = 1, lbN = 1, oeReqN = 1, drv = 0;
    logic oeN, doe, wcyc;
    logic [BURST_W-1:0] low = 2'h0;
    logic [ADDR_HIGH_W-1:0] hi = 14'h15A5;
    logic [DATA_W-1:0]  wd = 18'h00000, din, dout;
    logic [DATA_W-1:0]  exp [4];
    int n_errors = 0, n_tests = 0;
    // ----
    // Harness
    // ----
    always #5 ref_clk = ~ref_clk;
    sbsc_bus_master u_master (.ref_clk, .driveEn(drv), .oeReqN, .wrData(wd), .dataIn(din),
        .outputEnableN(oeN));
    sbsc_sram_control u_dut (.ref_clk, .sys_rst, .chipSelectPrimaryN(cs1N),
        .chipSelectHigh(cs2), .chipSelectExtraN(cs3N), .procAddrStrobeN(procN),
        .ctrlAddrStrobeN(ctrlN), .burstStepN(stepN), .burstOrderSelect(order),
        .allLanesWriteN(gwN), .laneWriteEnableN(weN), .laneAWriteN(laN), .laneBWriteN(lbN),
        .outputEnableN(oeN), .addressIn(hi), .addressLowBits(low), .dataIn(din),
        .dataOut(dout), .dataOe(doe), .writeCycle(wcyc));
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
        n_tests++;
        if (seen !== want) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic stop_test();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Beat address: order is static, so only change it between bursts
    function automatic logic [1:0] nxt(input logic [1:0] s, input logic [1:0] i);
        return order ? s ^ i : s + i;
    endfunction
    // ----
    // Scenarios
    // ----
    task automatic wr_burst(input logic [1:0] s, input logic [DATA_W-1:0] base);
        {ctrlN, gwN, drv, oeReqN} = 4'b0011;
        low = s;
        for (int i = 0; i < 4; i++) begin
            if (i > 0) {ctrlN, stepN} = 2'b10;
            wd = base + DATA_W'(i);
            tick();
            exp[nxt(s, i[1:0])] = wd;
            chk(wcyc, 1'b1);
            chk(doe, 1'b0);
        end
        {stepN, gwN, drv} = 3'b110;
    endtask
    task automatic rd_burst(input logic [1:0] s);
        {ctrlN, oeReqN} = 2'b00;
        low = s;
        for (int i = 0; i < 4; i++) begin
            if (i > 0) {ctrlN, stepN} = 2'b10;
            tick();
            chk(dout, exp[nxt(s, i[1:0])]);
            chk(doe, 1'b1);
        end
        stepN = 1;
        tick();
        chk(dout, exp[nxt(s, 2'h3)]);
    endtask
    // Byte writes only: global write held high, enable low
    task automatic t_lanes();
        {gwN, weN, drv, oeReqN, ctrlN} = 5'b10110;
        for (int k = 0; k < 4; k++) begin
            {lbN, laN} = k[1:0];
            low = k[1:0];
            wd = {16'hF0F0, k[1:0]};
            tick();
            if (!laN) exp[k][8:0] = wd[8:0];
            if (!lbN) exp[k][17:9] = wd[17:9];
            chk(wcyc, k != 3);
        end
        {weN, laN, lbN, drv} = 4'b1110;
        rd_burst(2'h0);
    endtask
    task automatic t_desel();
        logic [2:0] cs [3] = '{3'b110, 3'b000, 3'b011};
        {gwN, ctrlN, oeReqN} = 3'b000;
        for (int j = 0; j < 3; j++) begin
            {cs1N, cs2, cs3N} = cs[j];
            tick();
            chk(wcyc, 1'b0);
            chk(doe, 1'b0);
        end
        {cs1N, cs2, cs3N, gwN} = 4'b0101;
        rd_burst(2'h1);
    endtask
    task automatic t_proc();
        {procN, oeReqN} = 2'b00;
        low = 2'h2;
        tick();
        chk(dout, exp[2]);
        {cs1N, stepN} = 2'b10;
        tick();
        chk(dout, exp[nxt(2'h2, 2'h1)]);
        {procN, cs1N, stepN, oeReqN} = 4'b1011;
        #1 chk(doe, 1'b0);
        tick();
        chk(dout, exp[nxt(2'h2, 2'h1)]);
        oeReqN = 0;
        #1 chk(doe, 1'b1);
        tick();
        {gwN, drv} = 2'b01;
        wd = 18'h2D2D2;
        tick();
        exp[nxt(2'h2, 2'h1)] = wd;
        chk(wcyc, 1'b1);
        {gwN, drv} = 2'b10;
        rd_burst(nxt(2'h2, 2'h1));
    endtask
    // Upper address: taken from the pins on a strobe, held through the burst
    task automatic t_upper();
        {hi, low, ctrlN, gwN, drv, oeReqN} = {14'h0A5A, 2'h0, 4'b0011};
        wd = 18'h3C3C3;
        tick();
        chk(wcyc, 1'b1);
        {hi, gwN, drv, oeReqN} = {14'h15A5, 3'b100};
        tick();
        chk(dout, exp[0]);
        hi = 14'h0A5A;
        tick();
        chk(dout, 18'h3C3C3);
        {hi, ctrlN} = {14'h15A5, 1'b1};
        tick();
        chk(dout, 18'h3C3C3);
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        #1 sys_rst = 0;
        chk(dout, RST_DATA);
        chk(doe, 1'b0);
        wr_burst(2'h1, 18'h10000);
        rd_burst(2'h1);
        t_lanes();
        t_desel();
        t_proc();
        t_upper();
        order = 1;
        wr_burst(2'h1, 18'h20000);
        rd_burst(2'h2);
        stop_test();
    end
endmodule

// [verilog/sbsc_burst_counter.sv]
`timescale 1ns/1ps
module sbsc_burst_counter
    import sbsc_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               sys_rst,
    input  wire logic               load,
    input  wire logic [BURST_W-1:0] loadValue,
    input  wire logic               step,
    input  wire logic               interleaved,
    output logic      [BURST_W-1:0] currentLow,
    output logic      [BURST_W-1:0] steppedLow
);

    logic [BURST_W-1:0] base;
    logic [BURST_W-1:0] count;
    logic [BURST_W-1:0] next_base;
    logic [BURST_W-1:0] next_count;
    logic [BURST_W-1:0] countPlus;

    // ------------------------------------------------------------------
    // Address order
    // ------------------------------------------------------------------
    // Order select is read live, never latched, so it must stay static
    always_comb begin
        countPlus = count + BURST_ONE;
        if (interleaved) begin
            currentLow = base ^ count;
            steppedLow = base ^ countPlus;
        end else begin
            currentLow = base + count;
            steppedLow = base + countPlus;
        end
    end

    // Load restarts the sequence; step moves one place, wrapping at four
    always_comb begin
        next_base  = base;
        next_count = count;
        if (load) begin
            next_base  = loadValue;
            next_count = RST_BURST;
        end else if (step) begin
            next_count = countPlus;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            base  <= RST_BURST;
            count <= RST_BURST;
        end else begin
            base  <= next_base;
            count <= next_count;
        end
    end

endmodule

// [verilog/sbsc_pkg.sv]
package sbsc_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int DATA_W      = 18;
    localparam int LANE_W      = 9;
    localparam int ADDR_W      = 16;
    localparam int ADDR_HIGH_W = 14;
    localparam int BURST_W     = 2;
    localparam int MEM_DEPTH   = 65536;

    // Lane positions inside a data word
    localparam int LANE_A_LSB  = 0;
    localparam int LANE_B_LSB  = 9;

    // ------------------------------------------------------------------
    // Reset values and burst step
    // ------------------------------------------------------------------
    localparam logic [BURST_W-1:0]     RST_BURST = 2'h0;
    localparam logic [ADDR_HIGH_W-1:0] RST_ADDR  = 14'h0000;
    localparam logic [DATA_W-1:0]      RST_DATA  = 18'h00000;
    localparam logic [BURST_W-1:0]     BURST_ONE = 2'h1;

    // Cycle kind held between clock edges
    typedef enum logic [1:0] {
        MODE_IDLE,
        MODE_READ,
        MODE_WRITE
    } sbsc_mode_e;

endpackage

// [verilog/sbsc_sram_control.sv]
`timescale 1ns/1ps
module sbsc_sram_control
    import sbsc_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   sys_rst,
    input  wire logic                   chipSelectPrimaryN,
    input  wire logic                   chipSelectHigh,
    input  wire logic                   chipSelectExtraN,
    input  wire logic                   procAddrStrobeN,
    input  wire logic                   ctrlAddrStrobeN,
    input  wire logic                   burstStepN,
    input  wire logic                   burstOrderSelect,
    input  wire logic                   allLanesWriteN,
    input  wire logic                   laneWriteEnableN,
    input  wire logic                   laneAWriteN,
    input  wire logic                   laneBWriteN,
    input  wire logic                   outputEnableN,
    input  wire logic [ADDR_HIGH_W-1:0] addressIn,
    input  wire logic [BURST_W-1:0]     addressLowBits,
    input  wire logic [DATA_W-1:0]      dataIn,
    output logic      [DATA_W-1:0]      dataOut,
    output logic                        dataOe,
    output logic                        writeCycle
);

    // ------------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------------
    logic [DATA_W-1:0]      mem [MEM_DEPTH];
    sbsc_mode_e             mode;
    sbsc_mode_e             next_mode;
    logic [ADDR_HIGH_W-1:0] addrHigh;
    logic [ADDR_HIGH_W-1:0] next_addrHigh;
    logic [DATA_W-1:0]      next_dataOut;
    logic                   next_writeCycle;
    logic                   readDrive;
    logic                   next_readDrive;

    // Decode, address and lane terms
    logic                   selected;
    logic                   procStart;
    logic                   ctrlStart;
    logic                   anyStart;
    logic                   deselect;
    logic                   beginRead;
    logic                   beginWrite;
    logic                   isWrite;
    logic [1:0]             laneMask;
    logic                   loadBurst;
    logic                   stepBurst;
    logic                   doWrite;
    logic                   writeLaneA;
    logic                   writeLaneB;
    logic [BURST_W-1:0]     currentLow;
    logic [BURST_W-1:0]     steppedLow;
    logic [BURST_W-1:0]     useLow;
    logic [ADDR_HIGH_W-1:0] useHigh;
    logic [ADDR_W-1:0]      useAddr;
    logic [DATA_W-1:0]      readWord;

    // ------------------------------------------------------------------
    // Input decode
    // ------------------------------------------------------------------
    // Strobe and select qualification, all sampled on the same edge
    always_comb begin
        selected  = !chipSelectPrimaryN && chipSelectHigh && !chipSelectExtraN;
        procStart = !procAddrStrobeN && !chipSelectPrimaryN;
        ctrlStart = !ctrlAddrStrobeN && !procStart;
        anyStart  = procStart || ctrlStart;
    end

    // Write qualification and lane selection
    always_comb begin
        if (!allLanesWriteN) begin
            laneMask = 2'h3;
        end else if (!laneWriteEnableN) begin
            laneMask = {!laneBWriteN, !laneAWriteN};
        end else begin
            laneMask = 2'h0;
        end
        isWrite = |laneMask;
    end

    // Strobe cycle kind; a processor strobe ignores the write inputs
    always_comb begin
        deselect   = anyStart && !selected;
        beginRead  = anyStart && selected && (procStart || !isWrite);
        beginWrite = anyStart && selected && !procStart && isWrite;
    end

    // ------------------------------------------------------------------
    // Cycle selection
    // ------------------------------------------------------------------
    // Strobes win over the running burst; a deselected part waits for one
    always_comb begin
        next_mode     = mode;
        next_addrHigh = addrHigh;
        loadBurst     = 1'h0;
        stepBurst     = 1'h0;
        if (deselect) begin
            next_mode = MODE_IDLE;
        end else if (beginRead || beginWrite) begin
            loadBurst     = 1'h1;
            next_addrHigh = addressIn;
            next_mode     = beginWrite ? MODE_WRITE : MODE_READ;
        end else begin
            unique case (mode)
                MODE_IDLE: begin
                    // Deselected or fresh from reset: advance and writes ignored
                    next_mode = MODE_IDLE;
                end
                MODE_READ, MODE_WRITE: begin
                    // A processor-strobe read may turn into a write at one address
                    stepBurst = !burstStepN;
                    next_mode = isWrite ? MODE_WRITE : MODE_READ;
                end
                default: begin
                    // Unused code falls back to idle
                    next_mode = MODE_IDLE;
                end
            endcase
        end
    end

    // Cycle state; reset parks the part until a strobe opens a burst
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mode     <= MODE_IDLE;
            addrHigh <= RST_ADDR;
        end else begin
            mode     <= next_mode;
            addrHigh <= next_addrHigh;
        end
    end

    // ------------------------------------------------------------------
    // Burst address
    // ------------------------------------------------------------------
    // Low bits used this edge: external, next or current
    always_comb begin
        if (loadBurst) begin
            useLow = addressLowBits;
        end else if (stepBurst) begin
            useLow = steppedLow;
        end else begin
            useLow = currentLow;
        end
    end

    // High bits come from the pins only on a start, else from the register
    always_comb begin
        useHigh = loadBurst ? addressIn : addrHigh;
        useAddr = {useHigh, useLow};
    end

    sbsc_burst_counter u_burst (
        .ref_clk     (ref_clk),
        .sys_rst     (sys_rst),
        .load        (loadBurst),
        .loadValue   (addressLowBits),
        .step        (stepBurst),
        .interleaved (burstOrderSelect),
        .currentLow  (currentLow),
        .steppedLow  (steppedLow)
    );

    // ------------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------------
    // Array word at the address used this edge, before any write lands
    always_comb begin
        readWord = mem[useAddr];
    end

    // Flow-through: read data leaves the array on the edge that takes the address
    always_comb begin
        doWrite         = (next_mode == MODE_WRITE);
        next_dataOut    = doWrite ? dataOut : readWord;  // Last read word held through writes
        // Drive state follows the cycle just chosen
        next_readDrive  = (next_mode == MODE_READ);
        next_writeCycle = doWrite;
    end

    // Output registers; while idle the word reloads from the array at the held address
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dataOut    <= RST_DATA;
            readDrive  <= 1'h0;
            writeCycle <= 1'h0;
        end else begin
            dataOut    <= next_dataOut;
            readDrive  <= next_readDrive;
            writeCycle <= next_writeCycle;
        end
    end

    // ------------------------------------------------------------------
    // Write lanes
    // ------------------------------------------------------------------
    // Reset blocks writes, so a request held through reset cannot touch data
    always_comb begin
        writeLaneA = !sys_rst && doWrite && laneMask[0];
        writeLaneB = !sys_rst && doWrite && laneMask[1];
    end

    // Self-timed write, each lane under its own enable; no reset since array contents are data
    always_ff @(posedge ref_clk) begin
        if (writeLaneA) begin
            mem[useAddr][LANE_A_LSB +: LANE_W] <= dataIn[LANE_A_LSB +: LANE_W];
        end
        if (writeLaneB) begin
            mem[useAddr][LANE_B_LSB +: LANE_W] <= dataIn[LANE_B_LSB +: LANE_W];
        end
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    // Enable is left unclocked on purpose: pins must follow output enable at once
    always_comb begin
        dataOe = readDrive && !outputEnableN;
    end

endmodule
